/* shared/timer_integ_pkg.sv */
/*
  Constants shared by the timer integration block: register offsets,
  field positions, reset values, clock-source and trigger encodings.
  Assumes a 32-bit register port with byte addresses on word bounds.
*/
`default_nettype none
package timer_integ_pkg;
  // structure
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned N_UNIT  = 2;
  localparam int unsigned N_CH    = 2;
  localparam int unsigned N_EV    = 4;
  localparam int unsigned TB_UNIT = 1;
  localparam int unsigned CTRL_W  = 9;
  // register offsets
  localparam logic [7:0] OFS_CLK_CFG = 8'h00;
  localparam logic [7:0] OFS_CTRL0   = 8'h04;
  localparam logic [7:0] OFS_CTRL1   = 8'h08;
  localparam logic [7:0] OFS_MOD0    = 8'h0c;
  localparam logic [7:0] OFS_MOD1    = 8'h10;
  localparam logic [7:0] OFS_CNT0    = 8'h14;
  localparam logic [7:0] OFS_CNT1    = 8'h18;
  localparam logic [7:0] OFS_COMPARATOR_OUTPUT    = 8'h1c;
  localparam logic [7:0] OFS_STATUS  = 8'h2c;
  localparam logic [7:0] OFS_MASK    = 8'h30;
  localparam logic [7:0] OFS_STEP    = 8'h04;
  // clock configuration fields
  localparam int unsigned CFG_SRC_LSB = 0;
  localparam int unsigned CFG_SEL_LSB = 2;
  localparam logic [1:0] SRC_OFF  = 2'h0;
  localparam logic [1:0] SRC_OSC  = 2'h1;
  localparam logic [1:0] SRC_IRC  = 2'h2;
  localparam logic [1:0] SRC_FAST = 2'h3;
  // unit control fields
  localparam int unsigned CTL_COUNTER_CLOCK_MODE_LSB = 0;
  localparam int unsigned CTL_TRG_LSB  = 2;
  localparam int unsigned CTL_GTB      = 6;
  localparam int unsigned CTL_TSTART   = 7;
  localparam int unsigned CTL_TRELOAD  = 8;
  localparam logic [1:0] COUNTER_CLOCK_MODE_INT = 2'h1;
  localparam int unsigned COUNTER_CLOCK_MODE_EXT_BIT = 1;
  // trigger source codes
  localparam logic [3:0] TRG_PIN  = 4'h0;
  localparam logic [3:0] TRG_CMP  = 4'h1;
  localparam logic [3:0] TRG_OVF0 = 4'h8;
  localparam logic [3:0] TRG_OVF1 = 4'h9;
  localparam logic [3:0] TRG_ALM  = 4'hc;
  localparam logic [3:0] TRG_SEC  = 4'hd;
  localparam logic [3:0] TRG_LPT  = 4'he;
  // event bit positions within a unit
  localparam int unsigned EV_OVF = 0;
  localparam int unsigned EV_CH0 = 1;
  localparam int unsigned EV_TRG = 3;
  // reset values
  localparam logic [1:0]        RST_SRC  = 2'h0;
  localparam logic [CTRL_W-1:0] RST_CTRL = 9'h000;
  localparam logic [CNT_W-1:0]  RST_MOD  = 16'hffff;
  // synchroniser lanes
  localparam int unsigned SY_OSC  = 0;
  localparam int unsigned SY_IRC  = 1;
  localparam int unsigned SY_FAST = 2;
  localparam int unsigned SY_EXT0 = 3;
  localparam int unsigned SY_EXT1 = 4;
  localparam int unsigned SY_PIN  = 5;
  localparam int unsigned SY_CMP  = 6;
  localparam int unsigned SY_ALM  = 7;
  localparam int unsigned SY_SEC  = 8;
  localparam int unsigned SY_LPT  = 9;
  localparam int unsigned N_SYNC  = 10;
endpackage
`default_nettype wire

/* shared/timer_unit_if.sv */
/*
  Link between the integration logic and one timer unit: count tick,
  trigger, settings in; counter, overflow and match pulses out.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface timer_unit_if;
  import timer_integ_pkg::*;
  logic                          tick;
  logic                          trig;
  logic                          start_en;
  logic                          reload_en;
  logic                          gtb;
  logic [CNT_W-1:0]              modulo;
  logic [N_CH-1:0][CNT_W-1:0]    cmp;
  logic [CNT_W-1:0]              tb_cnt;
  logic                          tb_ovf;
  logic [CNT_W-1:0]              cnt;
  logic                          ovf;
  logic [N_CH-1:0]               match;
  modport ctl (output tick, trig, start_en, reload_en, gtb, modulo, cmp,
               output tb_cnt, tb_ovf, input cnt, ovf, match);
  modport unit (input tick, trig, start_en, reload_en, gtb, modulo, cmp,
                input tb_cnt, tb_ovf, output cnt, ovf, match);
endinterface
`default_nettype wire

/* rtl/timer_unit.sv */
/*
  One timer unit: counter with modulo wrap, trigger start and reload,
  two compare channels and an optional shared timebase.
  Assumes tick and trig are one-cycle pulses on clk.
*/
`timescale 1ns/10ps
`default_nettype none
module timer_unit
  import timer_integ_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  timer_unit_if.unit       tu
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             run;
    logic             ovf;
    logic [N_CH-1:0]  match;
  } unit_st_t;

  unit_st_t s_q;
  unit_st_t s_d;
  logic     go;

  // counter, start latch and compare detection
  always_comb begin
    s_d = s_q;
    s_d.ovf = 1'b0;
    s_d.match = '0;
    go = !tu.start_en || s_q.run;
    if (tu.trig && tu.start_en) begin
      s_d.run = 1'b1;
    end
    if (tu.gtb) begin
      s_d.cnt = tu.tb_cnt;
      s_d.ovf = tu.tb_ovf;
    end else if (tu.trig && tu.reload_en) begin
      s_d.cnt = '0;
    end else if (tu.tick && go) begin
      if (s_q.cnt == tu.modulo) begin
        s_d.cnt = '0;
        s_d.ovf = 1'b1;
      end else begin
        s_d.cnt = CNT_W'(s_q.cnt + 1'b1);
      end
    end
    // each channel flags when the counter lands on its value
    for (int k = 0; k < N_CH; k++) begin
      s_d.match[k] = (s_d.cnt != s_q.cnt) && (s_d.cnt == tu.cmp[k]);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // results back to the integration logic
  assign tu.cnt   = s_q.cnt;
  assign tu.ovf   = s_q.ovf;
  assign tu.match = s_q.match;
endmodule
`default_nettype wire

/* rtl/timer_clock_trigger_integration.sv */
/*
  Integration logic around two timer units: shared counter clock
  selection, external clock mode, trigger multiplexers, global
  timebase, register port and one combined interrupt request.
  Assumes clock sources and trigger inputs arrive from other domains
  and are slower than half of clk; register strobes are one cycle.
*/
// Our own choices: the placing of the registers and the address-and-strobe port.
// Operation
// - Two independent timer units are built, each with two channels.
// - Units are basic timers only and keep counting in stop modes, except on the fast clock.
// - In stop modes the counter clock is an external or internal one.
// - One select picks the shared counter clock from three sources.
// - Counter mode 1x counts synchronised rising edges of an ext clock.
// - Per unit, a select picks one of the two external clock inputs.
// - A selected trigger starts the counter, reloads it, or both.
// - Trigger codes map to pin, comparator, overflows, RTC and LP timer.
// - With global timebase set, a unit follows the counter of unit 1.
// - All interrupt sources of a unit are ORed into one request line.
`timescale 1ns/10ps
`default_nettype none
module timer_clock_trigger_integration
  import timer_integ_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              oscillator_ref_clock,
  input  wire logic              internal_ref_clock,
  input  wire logic              fast_peripheral_clock,
  input  wire logic              stop_mode,
  input  wire logic              very_low_power_stop,
  input  wire logic              ext_clock_input_0,
  input  wire logic              ext_clock_input_1,
  input  wire logic              trigger_pin_input,
  input  wire logic              comparator_output,
  input  wire logic              rtc_alarm,
  input  wire logic              rtc_seconds,
  input  wire logic              low_power_timer_trigger,
  output logic      [N_UNIT-1:0] irq_req,
  output logic                   irq
);
  typedef struct packed {
    logic [N_SYNC-1:0]                      s1;
    logic [N_SYNC-1:0]                      s2;
    logic [N_SYNC-1:0]                      s3;
    logic [N_SYNC-1:0]                      lvl;
    logic [1:0]                             stop_s1;
    logic [1:0]                             stop_s2;
    logic [1:0]                             stop_s3;
    logic [1:0]                             stop_lvl;
    logic [N_UNIT-1:0]                      ext_smp;
    logic [1:0]                             src;
    logic [N_UNIT-1:0]                      ext_sel;
    logic [N_UNIT-1:0][CTRL_W-1:0]          ctrl;
    logic [N_UNIT-1:0][CNT_W-1:0]           modulo;
    logic [N_UNIT-1:0][N_CH-1:0][CNT_W-1:0] cmp;
    logic [N_UNIT*N_EV-1:0]                 status;
    logic [N_UNIT*N_EV-1:0]                 mask;
    logic [N_UNIT-1:0]                      irq_req;
    logic                                   irq;
    logic [DATA_W-1:0]                      rdata;
  } top_st_t;

  top_st_t                    s_q;
  top_st_t                    s_d;
  logic [N_SYNC-1:0]          raw;
  logic [N_SYNC-1:0]          rise;
  logic                       stopped;
  logic                       tclk_rise;
  logic [N_UNIT-1:0]          tick;
  logic [N_UNIT-1:0]          trig;
  logic [N_UNIT-1:0]          ext_lvl;
  logic [N_UNIT-1:0][CNT_W-1:0] cnt_v;
  logic [N_UNIT-1:0]          ovf_v;
  logic [N_UNIT-1:0][N_CH-1:0] match_v;
  logic [N_UNIT*N_EV-1:0]     ev;
  logic [N_UNIT*N_EV-1:0]     clr;

  // picks one trigger for a unit; unlisted codes stay low
  function automatic logic trig_pick(
    input logic [3:0]        sel,
    input logic [N_SYNC-1:0] r,
    input logic [N_UNIT-1:0] o
  );
    logic t;
    t = 1'b0;
    case (sel)
      TRG_PIN:  t = r[SY_PIN];
      TRG_CMP:  t = r[SY_CMP];
      TRG_OVF0: t = o[0];
      TRG_OVF1: t = o[1];
      TRG_ALM:  t = r[SY_ALM];
      TRG_SEC:  t = r[SY_SEC];
      TRG_LPT:  t = r[SY_LPT];
      default:  t = 1'b0;
    endcase
    return t;
  endfunction

  // lanes that cross in from other clock domains
  assign raw[SY_OSC]  = oscillator_ref_clock;
  assign raw[SY_IRC]  = internal_ref_clock;
  assign raw[SY_FAST] = fast_peripheral_clock;
  assign raw[SY_EXT0] = ext_clock_input_0;
  assign raw[SY_EXT1] = ext_clock_input_1;
  assign raw[SY_PIN]  = trigger_pin_input;
  assign raw[SY_CMP]  = comparator_output;
  assign raw[SY_ALM]  = rtc_alarm;
  assign raw[SY_SEC]  = rtc_seconds;
  assign raw[SY_LPT]  = low_power_timer_trigger;

  // a level counts once stages two and three agree
  assign rise = s_q.s2 & s_q.s3 & ~s_q.lvl;
  assign stopped = |s_q.stop_lvl;

  // shared counter clock; the fast clock is gone in stop modes
  always_comb begin
    tclk_rise = 1'b0;
    case (s_q.src)
      SRC_OSC:  tclk_rise = rise[SY_OSC];
      SRC_IRC:  tclk_rise = rise[SY_IRC];
      SRC_FAST: tclk_rise = rise[SY_FAST] & ~stopped;
      default:  tclk_rise = 1'b0;
    endcase
  end

  // per unit: count source and trigger selection
  always_comb begin
    tick = '0;
    trig = '0;
    ext_lvl = '0;
    for (int u = 0; u < N_UNIT; u++) begin
      ext_lvl[u] = s_q.ext_sel[u] ? s_q.lvl[SY_EXT1]
                                  : s_q.lvl[SY_EXT0];
      if (s_q.ctrl[u][CTL_COUNTER_CLOCK_MODE_LSB+COUNTER_CLOCK_MODE_EXT_BIT]) begin
        tick[u] = tclk_rise & ext_lvl[u] & ~s_q.ext_smp[u];
      end else if (s_q.ctrl[u][CTL_COUNTER_CLOCK_MODE_LSB+:2] == COUNTER_CLOCK_MODE_INT) begin
        tick[u] = tclk_rise;
      end
      trig[u] = trig_pick(s_q.ctrl[u][CTL_TRG_LSB+:4], rise, ovf_v);
    end
  end

  // the two timer units, each on its own link
  for (genvar g = 0; g < N_UNIT; g++) begin : g_unit
    timer_unit_if tu ();
    assign tu.tick      = tick[g];
    assign tu.trig      = trig[g];
    assign tu.start_en  = s_q.ctrl[g][CTL_TSTART];
    assign tu.reload_en = s_q.ctrl[g][CTL_TRELOAD];
    assign tu.gtb       = s_q.ctrl[g][CTL_GTB];
    assign tu.modulo    = s_q.modulo[g];
    assign tu.cmp       = s_q.cmp[g];
    assign tu.tb_cnt    = cnt_v[TB_UNIT];
    assign tu.tb_ovf    = ovf_v[TB_UNIT];
    assign cnt_v[g]     = tu.cnt;
    assign ovf_v[g]     = tu.ovf;
    assign match_v[g]   = tu.match;
    timer_unit u_unit (
      .clk   (clk),
      .rst_b (rst_b),
      .tu    (tu.unit)
    );
  end

  // events per unit: overflow, channel matches, trigger
  always_comb begin
    ev = '0;
    for (int u = 0; u < N_UNIT; u++) begin
      ev[u*N_EV+EV_OVF] = ovf_v[u];
      for (int k = 0; k < N_CH; k++) begin
        ev[u*N_EV+EV_CH0+k] = match_v[u][k];
      end
      ev[u*N_EV+EV_TRG] = trig[u];
    end
  end

  // write-one-to-clear mask for the status register
  assign clr = (reg_wr && reg_addr == OFS_STATUS)
             ? reg_wdata[N_UNIT*N_EV-1:0] : '0;

  // next state: synchronisers, register writes, flags, read data
  always_comb begin
    s_d = s_q;
    s_d.s1 = raw;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.lvl = (s_q.s2 & s_q.s3) | (s_q.lvl & (s_q.s2 ^ s_q.s3));
    // stop requests come from another domain, same three-stage filter
    s_d.stop_s1 = {very_low_power_stop, stop_mode};
    s_d.stop_s2 = s_q.stop_s1;
    s_d.stop_s3 = s_q.stop_s2;
    s_d.stop_lvl = (s_q.stop_s2 & s_q.stop_s3)
                 | (s_q.stop_lvl & (s_q.stop_s2 ^ s_q.stop_s3));
    // ext level sampled on the timer clock for edge detect
    for (int u = 0; u < N_UNIT; u++) begin
      if (tclk_rise) begin
        s_d.ext_smp[u] = ext_lvl[u];
      end
    end
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_CLK_CFG: begin
          s_d.src = reg_wdata[CFG_SRC_LSB+:2];
          s_d.ext_sel = reg_wdata[CFG_SEL_LSB+:N_UNIT];
        end
        OFS_CTRL0: s_d.ctrl[0] = reg_wdata[CTRL_W-1:0];
        OFS_CTRL1: s_d.ctrl[1] = reg_wdata[CTRL_W-1:0];
        OFS_MOD0:  s_d.modulo[0] = reg_wdata[CNT_W-1:0];
        OFS_MOD1:  s_d.modulo[1] = reg_wdata[CNT_W-1:0];
        OFS_MASK:  s_d.mask = reg_wdata[N_UNIT*N_EV-1:0];
        default: begin
        end
      endcase
      for (int u = 0; u < N_UNIT; u++) begin
        for (int k = 0; k < N_CH; k++) begin
          if (reg_addr == 8'(OFS_COMPARATOR_OUTPUT + OFS_STEP * (u*N_CH + k))) begin
            s_d.cmp[u][k] = reg_wdata[CNT_W-1:0];
          end
        end
      end
    end
    // sticky flags: a new event beats a clear in the same cycle
    s_d.status = (s_q.status & ~clr) | ev;
    // one request per unit, then one for the whole block
    for (int u = 0; u < N_UNIT; u++) begin
      s_d.irq_req[u] = |(s_d.status[u*N_EV+:N_EV]
                       & s_d.mask[u*N_EV+:N_EV]);
    end
    s_d.irq = |s_d.irq_req;
    // read data stand only in the cycle after the strobe
    s_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CLK_CFG: s_d.rdata = DATA_W'({s_q.ext_sel, s_q.src});
        OFS_CTRL0:   s_d.rdata = DATA_W'(s_q.ctrl[0]);
        OFS_CTRL1:   s_d.rdata = DATA_W'(s_q.ctrl[1]);
        OFS_MOD0:    s_d.rdata = DATA_W'(s_q.modulo[0]);
        OFS_MOD1:    s_d.rdata = DATA_W'(s_q.modulo[1]);
        OFS_CNT0:    s_d.rdata = DATA_W'(cnt_v[0]);
        OFS_CNT1:    s_d.rdata = DATA_W'(cnt_v[1]);
        OFS_STATUS:  s_d.rdata = DATA_W'(s_q.status);
        OFS_MASK:    s_d.rdata = DATA_W'(s_q.mask);
        default:     s_d.rdata = '0;
      endcase
      for (int u = 0; u < N_UNIT; u++) begin
        for (int k = 0; k < N_CH; k++) begin
          if (reg_addr == 8'(OFS_COMPARATOR_OUTPUT + OFS_STEP * (u*N_CH + k))) begin
            s_d.rdata = DATA_W'(s_q.cmp[u][k]);
          end
        end
      end
    end
  end

  // state register with documented reset values
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.src <= RST_SRC;
      s_q.ctrl <= {N_UNIT{RST_CTRL}};
      s_q.modulo <= {N_UNIT{RST_MOD}};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = s_q.rdata;
  assign irq_req   = s_q.irq_req;
  assign irq       = s_q.irq;
endmodule
`default_nettype wire

/* dv/source_model.sv */
/*
  Far side of the timer integration block: clock sources, external
  clock inputs and trigger sources. Assumes the bench requests ext
  bursts and trigger pulses with one-cycle strobes on clk.
*/
`timescale 1ns/10ps
`default_nettype none
module source_model (
  input  wire logic       clk,
  input  wire logic [1:0] ext_burst,
  input  wire logic       trg_go,
  output logic            oscillator_ref_clock,
  output logic            internal_ref_clock,
  output logic            fast_peripheral_clock,
  output logic            ext_clock_input_0,
  output logic            ext_clock_input_1,
  output logic            trigger_pin_input,
  output logic            comparator_output,
  output logic            rtc_alarm,
  output logic            rtc_seconds,
  output logic            low_power_timer_trigger
);
  // oscillators run free, unrelated in phase to clk
  initial begin
    oscillator_ref_clock = 1'b0;
    forever #400 oscillator_ref_clock = ~oscillator_ref_clock;
  end
  initial begin
    internal_ref_clock = 1'b0;
    forever #1300 internal_ref_clock = ~internal_ref_clock;
  end
  initial begin
    fast_peripheral_clock = 1'b0;
    forever #250 fast_peripheral_clock = ~fast_peripheral_clock;
  end
  // four slow rising edges per request, well under half the timer clock rate
  initial begin
    ext_clock_input_0 = 1'b0;
    forever begin
      @(posedge clk iff ext_burst[0]);
      repeat (4) begin
        #1000 ext_clock_input_0 = 1'b1;
        #1000 ext_clock_input_0 = 1'b0;
      end
    end
  end
  initial begin
    ext_clock_input_1 = 1'b0;
    forever begin
      @(posedge clk iff ext_burst[1]);
      repeat (4) begin
        #1000 ext_clock_input_1 = 1'b1;
        #1000 ext_clock_input_1 = 1'b0;
      end
    end
  end
  // every trigger source pulses high together, low otherwise
  initial begin
    {trigger_pin_input, comparator_output, rtc_alarm, rtc_seconds,
     low_power_timer_trigger} = 5'h00;
    forever begin
      @(posedge clk iff trg_go);
      #300 {trigger_pin_input, comparator_output, rtc_alarm, rtc_seconds,
            low_power_timer_trigger} = 5'h1f;
      #2000 {trigger_pin_input, comparator_output, rtc_alarm, rtc_seconds,
             low_power_timer_trigger} = 5'h00;
    end
  end
endmodule
`default_nettype wire

/* dv/timer_integ_checker.sv */
/*
  Port checks of the timer integration block's register port and
  interrupt outputs. Assumes binding to the top module, one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module timer_integ_checker
  import timer_integ_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [N_UNIT-1:0] irq_req,
  input wire logic              irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // read data and interrupt relations
  chk_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside read answer");
  chk_irq_or_units: assert property (irq == |irq_req)
    else $error("irq differs from OR of unit requests");
  chk_unmapped_read: assert property (reg_rd && reg_addr == 8'h40
    |=> reg_rdata == '0) else $error("unmapped read not zero");
  chk_status_width: assert property (reg_rd && reg_addr == OFS_STATUS
    |=> reg_rdata[31:8] == '0) else $error("status upper bits set");
  chk_ctrl_width: assert property (reg_rd && (reg_addr == OFS_CTRL0 ||
    reg_addr == OFS_CTRL1) |=> reg_rdata[31:9] == '0)
    else $error("control upper bits set");
  chk_mod_width: assert property (reg_rd && reg_addr == OFS_MOD0
    |=> reg_rdata[31:16] == '0) else $error("modulo upper bits set");
  chk_mask_quiets_irq: assert property (reg_wr && reg_addr == OFS_MASK &&
    reg_wdata[7:0] == 8'h00 |=> irq_req == '0)
    else $error("request stays high with all masked");
  chk_cfg_readback: assert property (reg_wr && reg_addr == OFS_CLK_CFG ##1
    reg_rd && reg_addr == OFS_CLK_CFG |=> reg_rdata ==
    {28'h0000000, $past(reg_wdata[3:0], 2)})
    else $error("clock config readback wrong");
  cov_irq_rise: cover property ($rose(irq));
  cov_status_read: cover property (reg_rd && reg_addr == OFS_STATUS);
  cov_cfg_readback: cover property (reg_wr ##1 reg_rd);
endmodule
`default_nettype wire

/* dv/tb.sv */
/*
  Self-checking bench of the timer integration block: register
  access tasks and scenarios. Assumes the source model drives clocks
  and triggers; the bench drives the stop inputs.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import timer_integ_pkg::*;
  logic clk, rst_b, reg_wr, reg_rd, trg_go, irq;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [N_UNIT-1:0] irq_req;
  logic [1:0] ext_burst;
  logic [1:0] stop_req;
  wire logic osc, irc, fst, ex0, ex1, pin, cmpo, alm, sec, lpt;
  int num_errors, comparisons;
  source_model src (.clk, .ext_burst, .trg_go,
    .oscillator_ref_clock(osc), .internal_ref_clock(irc),
    .fast_peripheral_clock(fst), .ext_clock_input_0(ex0),
    .ext_clock_input_1(ex1), .trigger_pin_input(pin),
    .comparator_output(cmpo), .rtc_alarm(alm), .rtc_seconds(sec),
    .low_power_timer_trigger(lpt));
  timer_clock_trigger_integration dut (.clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .oscillator_ref_clock(osc),
    .internal_ref_clock(irc), .fast_peripheral_clock(fst),
    .stop_mode(stop_req[0]), .very_low_power_stop(stop_req[1]),
    .ext_clock_input_0(ex0), .ext_clock_input_1(ex1),
    .trigger_pin_input(pin), .comparator_output(cmpo), .rtc_alarm(alm),
    .rtc_seconds(sec), .low_power_timer_trigger(lpt), .irq_req, .irq);
  // clock and reset
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // register port accesses
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, e);
  endtask
  task automatic wrrd(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, {28'h0000000, d[3:0]});
  endtask
  // one trigger request, then time for it to settle
  task automatic trg_pulse();
    @(posedge clk);
    trg_go <= 1'b1;
    @(posedge clk);
    trg_go <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    final_report();
  end
  logic exp_t;
  initial begin
    {rst_b, reg_wr, reg_rd, trg_go, ext_burst, stop_req} = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    // reset values, unmapped place
    rd(OFS_CLK_CFG, 32'h00000000);
    rd(OFS_CTRL0, 32'h00000000);
    rd(OFS_MOD0, 32'h0000ffff);
    rd(OFS_STATUS, 32'h00000000);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h00000000);
    $display("test reset_values done");
    for (int s = 1; s < 4; s++) wrrd(OFS_CLK_CFG, 32'h0000000c | s);
    $display("test clock_select done");
    // unit0 counts edges of input1 only
    wr(OFS_CLK_CFG, 32'h00000005);
    wr(OFS_CTRL0, 32'h00000002);
    @(posedge clk);
    ext_burst <= 2'b11;
    @(posedge clk);
    ext_burst <= 2'b00;
    repeat (120) @(posedge clk);
    rd(OFS_CNT0, 32'h00000004);
    rd(OFS_CNT1, 32'h00000000);
    $display("test ext_clock done");
    // every trigger code; unit0 on a reserved code throughout
    wr(OFS_CTRL0, 32'h00000008);
    wr(OFS_STATUS, 32'h000000ff);
    for (int c = 0; c < 16; c++) begin
      exp_t = c inside {0, 1, 12, 13, 14};
      wr(OFS_CTRL1, c << 2);
      @(posedge clk);
      trg_go <= 1'b1;
      @(posedge clk);
      trg_go <= 1'b0;
      repeat (30) @(posedge clk);
      rd(OFS_STATUS, {24'h000000, exp_t, 7'h00});
      wr(OFS_STATUS, 32'h000000ff);
    end
    $display("test trigger_codes done");
    // interrupt raise, mask, unmask, clear
    wr(OFS_MASK, 32'h00000080);
    wr(OFS_CTRL1, {26'h0, TRG_PIN, 2'h0});
    @(posedge clk);
    trg_go <= 1'b1;
    @(posedge clk);
    trg_go <= 1'b0;
    repeat (30) @(posedge clk);
    check({30'h0, irq_req}, 32'h00000002);
    wr(OFS_MASK, 32'h00000000);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h00000000);
    wr(OFS_MASK, 32'h00000080);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h00000001);
    wr(OFS_STATUS, 32'h00000080);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h00000000);
    rd(OFS_STATUS, 32'h00000000);
    $display("test interrupt done");
    // start waits for the pin trigger, then ch0 flags at five
    wr(OFS_COMPARATOR_OUTPUT, 32'h00000005);
    rd(OFS_COMPARATOR_OUTPUT, 32'h00000005);
    wr(OFS_CTRL0, 32'h00000081);
    repeat (30) @(posedge clk);
    rd(OFS_CNT0, 32'h00000004);
    trg_pulse();
    rd(OFS_STATUS, 32'h0000008a);
    wr(OFS_CTRL0, 32'h00000100);
    trg_pulse();
    rd(OFS_CNT0, 32'h00000000);
    $display("test start_reload done");
    // unit1 wraps at three on the fast clock, unit0 follows it
    @(posedge clk);
    stop_req <= 2'b01;
    wr(OFS_CLK_CFG, 32'h00000003);
    wr(OFS_MOD1, 32'h00000003);
    wr(OFS_CTRL1, 32'h00000001);
    wr(OFS_CTRL0, 32'h00000040);
    repeat (4) @(posedge clk);
    wr(OFS_STATUS, 32'h000000ff);
    repeat (30) @(posedge clk);
    stop_req <= 2'b10;
    repeat (30) @(posedge clk);
    rd(OFS_STATUS, 32'h00000000);
    @(posedge clk);
    stop_req <= 2'b00;
    repeat (60) @(posedge clk);
    rd(OFS_STATUS, 32'h00000075);
    $display("test timebase_stop done");
    final_report();
  end
endmodule
bind timer_clock_trigger_integration timer_integ_checker chk (.clk(clk),
  .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_req(irq_req), .irq(irq));
`default_nettype wire
